// [nvh_pkg.sv]
// constants for the nonvolatile sram host: sequence addresses and timing
// assumes a 100 MHz system clock and the slow speed grade of the memory
package nvh_pkg;
  // widths of the memory pins
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int SEQ_ADDR_W = 14;   // only the low bits select sequence steps
  localparam int STEP_W = 3;
  localparam logic [STEP_W-1:0] STEP_LAST = 3'h5;  // sixth read, 0-based
  localparam logic [STEP_W-1:0] STEP_FIRST = 3'h0;
  localparam int PREFIX_LEN = 5;

  // fixed prefix of five reads shared by save and restore
  localparam logic [0:PREFIX_LEN-1][SEQ_ADDR_W-1:0] SEQ_PREFIX = {
    14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f, 14'h303f};
  localparam logic [SEQ_ADDR_W-1:0] SEQ_SAVE_LAST = 14'h0fc0;
  localparam logic [SEQ_ADDR_W-1:0] SEQ_RESTORE_LAST = 14'h0c63;

  // clock and access timing
  localparam int CLK_NS = 10;
  localparam int ACCESS_NS = 45;    // chip select access time, slow grade
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_STAGES = 2;   // data input synchroniser depth
  localparam int STROBE_CYC = ACCESS_CYC + SYNC_STAGES;

  // nonvolatile busy times
  localparam int SAVE_DURATION_MS = 10;
  localparam int RESTORE_DURATION_US = 20;
  localparam int POWERUP_RESTORE_DURATION_US = 550;
  localparam int SAVE_CYC = SAVE_DURATION_MS * 1000000 / CLK_NS;
  localparam int RESTORE_CYC = RESTORE_DURATION_US * 1000 / CLK_NS;
  localparam int POWERUP_CYC = POWERUP_RESTORE_DURATION_US * 1000 / CLK_NS;
  localparam int CNT_W = 20;

  // controller states
  typedef enum logic [2:0] {
    ST_PWRUP, ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER, ST_NVWAIT
  } nvh_state_t;
endpackage

// [nvh_timer.sv]
// down counter used for strobe widths and nonvolatile busy waits
// assumes a single clock; load wins over counting
`timescale 1ns/1ps
module nvh_timer #(
  parameter int CNT_W = 20,
  parameter logic [CNT_W-1:0] INIT = '0
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic load_i,
  input wire logic [CNT_W-1:0] load_val_i,
  output logic done_o
);
  logic [CNT_W-1:0] count_reg;  // cycles left
  logic [CNT_W-1:0] count_next;
  wire count_zero = (count_reg == '0);

  // reload, else count down and rest at zero
  assign count_next = load_i ? load_val_i :
                      count_zero ? count_reg : count_reg - 1'b1;
  // done ignores load so no loop runs back through the caller's decode;
  // the host never loads while it waits on done
  assign done_o = count_zero;

  // counter register starts at the power-up wait
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      count_reg <= INIT;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule

// [nvh_host.sv]
// host controller for an asynchronous nonvolatile sram with software
// save and restore; drives address, chip select, write and output gate.
// assumes the memory pins are wired straight to the device and that the
// bidirectional data wire is resolved outside from dq_oe_o.
`timescale 1ns/1ps
module nvh_host #(
  parameter int SAVE_CYCLES = nvh_pkg::SAVE_CYC,
  parameter int RESTORE_CYCLES = nvh_pkg::RESTORE_CYC,
  parameter int POWERUP_CYCLES = nvh_pkg::POWERUP_CYC
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [nvh_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [nvh_pkg::DATA_W-1:0] req_wdata_i,
  input wire logic save_req_i,
  input wire logic restore_req_i,
  output logic ready_o,
  output logic rd_valid_o,
  output logic [nvh_pkg::DATA_W-1:0] rd_data_o,
  output logic nv_done_o,
  output logic busy_o,
  output logic [nvh_pkg::ADDR_W-1:0] mem_addr_o,
  output logic mem_ce_n_o,
  output logic mem_we_n_o,
  output logic mem_oe_n_o,
  output logic [nvh_pkg::DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe_o,
  input wire logic [nvh_pkg::DATA_W-1:0] mem_dq_i
);
  localparam int CW = nvh_pkg::CNT_W;

  // refuse counts the timer cannot hold
  if (SAVE_CYCLES < 1 || SAVE_CYCLES >= 2**CW ||
      RESTORE_CYCLES < 1 || RESTORE_CYCLES >= 2**CW ||
      POWERUP_CYCLES < 1 || POWERUP_CYCLES >= 2**CW ||
      nvh_pkg::STROBE_CYC < 1) begin : g_bad_count
    $error("nvh_host: timing count out of timer range");
  end

  nvh_pkg::nvh_state_t state_reg, state_next;  // controller state
  logic [nvh_pkg::ADDR_W-1:0] addr_reg, addr_next;  // address on the pins
  logic [nvh_pkg::DATA_W-1:0] wdata_reg, wdata_next;  // write data
  logic is_write_reg, is_write_next;  // current access is a write
  logic in_seq_reg, in_seq_next;  // walking a save or restore sequence
  logic kind_reg, kind_next;  // 1 restore, 0 save
  logic [nvh_pkg::STEP_W-1:0] step_reg, step_next;  // sequence step
  logic ce_n_reg, we_n_reg, oe_n_reg, dq_oe_reg;  // registered pin strobes
  logic [nvh_pkg::DATA_W-1:0] dq_meta_reg, dq_sync_reg;  // synchroniser
  logic [nvh_pkg::DATA_W-1:0] rdata_reg;  // captured read data
  logic rd_valid_reg, nv_done_reg;  // one-cycle answers
  logic timer_load;
  logic [CW-1:0] timer_val;
  logic timer_done;

  // decode of the idle-time requests, save first, then restore, then access
  wire in_idle = (state_reg == nvh_pkg::ST_IDLE);
  wire take_save = in_idle && save_req_i;
  wire take_restore = in_idle && !save_req_i && restore_req_i;
  wire take_seq = take_save || take_restore;
  wire take_acc = in_idle && !take_seq && req_valid_i;
  wire strobe_end = (state_reg == nvh_pkg::ST_STROBE) && timer_done;
  wire seq_last = (step_reg == nvh_pkg::STEP_LAST);
  wire [nvh_pkg::STEP_W-1:0] step_inc = step_reg + 1'b1;

  // next step address from registers only, so no comb loop; top bit zero
  wire [nvh_pkg::SEQ_ADDR_W-1:0] last_addr = kind_reg ?
       nvh_pkg::SEQ_RESTORE_LAST : nvh_pkg::SEQ_SAVE_LAST;
  wire [nvh_pkg::SEQ_ADDR_W-1:0] seq_addr_sel =
       (step_inc == nvh_pkg::STEP_LAST) ? last_addr :
       nvh_pkg::SEQ_PREFIX[step_inc];
  wire [CW-1:0] busy_val = kind_reg ? CW'(RESTORE_CYCLES - 1) :
                           CW'(SAVE_CYCLES - 1);

  // next-state logic; user requests wait while a sequence runs, so nothing
  // can break into the six reads
  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    is_write_next = is_write_reg;
    in_seq_next = in_seq_reg;
    kind_next = kind_reg;
    step_next = step_reg;
    timer_load = 1'b0;
    timer_val = CW'(nvh_pkg::STROBE_CYC - 1);
    unique case (state_reg)
      nvh_pkg::ST_PWRUP: begin
        // device restores itself after supply comes up; wait it out
        if (timer_done) begin
          state_next = nvh_pkg::ST_IDLE;
        end
      end
      nvh_pkg::ST_IDLE: begin
        if (take_seq) begin
          in_seq_next = 1'b1;
          kind_next = take_restore;
          step_next = nvh_pkg::STEP_FIRST;
          is_write_next = 1'b0;
          addr_next = {1'b0, nvh_pkg::SEQ_PREFIX[nvh_pkg::STEP_FIRST]};
          state_next = nvh_pkg::ST_SETUP;
        end else if (take_acc) begin
          in_seq_next = 1'b0;
          is_write_next = req_write_i;
          addr_next = req_addr_i;
          wdata_next = req_wdata_i;
          state_next = nvh_pkg::ST_SETUP;
        end
      end
      nvh_pkg::ST_SETUP: begin
        // address settled one cycle with chip select high
        timer_load = 1'b1;
        state_next = nvh_pkg::ST_STROBE;
      end
      nvh_pkg::ST_STROBE: begin
        if (timer_done) begin
          state_next = nvh_pkg::ST_RECOVER;
        end
      end
      nvh_pkg::ST_RECOVER: begin
        // chip select high again; each step gets its own falling edge
        if (in_seq_reg && seq_last) begin
          timer_load = 1'b1;
          timer_val = busy_val;
          state_next = nvh_pkg::ST_NVWAIT;
        end else if (in_seq_reg) begin
          step_next = step_inc;
          addr_next = {1'b0, seq_addr_sel};
          state_next = nvh_pkg::ST_SETUP;
        end else begin
          state_next = nvh_pkg::ST_IDLE;
        end
      end
      nvh_pkg::ST_NVWAIT: begin
        // device is deaf until the nonvolatile cycle is over
        if (timer_done) begin
          in_seq_next = 1'b0;
          state_next = nvh_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = nvh_pkg::ST_IDLE;
      end
    endcase
  end

  // pin strobes for the coming state, registered so the pins never glitch
  wire strobe_next = (state_next == nvh_pkg::ST_STROBE);
  wire ce_n_next = !strobe_next;
  wire we_n_next = !(strobe_next && is_write_next);
  wire oe_n_next = !(strobe_next && !is_write_next);
  wire dq_oe_next = strobe_next && is_write_next;

  // state and access registers
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= nvh_pkg::ST_PWRUP;
      addr_reg <= '0;
      wdata_reg <= '0;
      is_write_reg <= 1'b0;
      in_seq_reg <= 1'b0;
      kind_reg <= 1'b0;
      step_reg <= '0;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      is_write_reg <= is_write_next;
      in_seq_reg <= in_seq_next;
      kind_reg <= kind_next;
      step_reg <= step_next;
    end
  end

  // pin strobe registers, ce, we and oe idle high and dq_oe_reg low after reset
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ce_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      dq_oe_reg <= 1'b0;
    end else begin
      ce_n_reg <= ce_n_next;
      we_n_reg <= we_n_next;
      oe_n_reg <= oe_n_next;
      dq_oe_reg <= dq_oe_next;
    end
  end

  // two-stage synchroniser for the data pins
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      dq_meta_reg <= '0;
      dq_sync_reg <= '0;
    end else begin
      dq_meta_reg <= mem_dq_i;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  // capture read data; sequence reads are discarded, the sixth floats
  wire capture = strobe_end && !is_write_reg && !in_seq_reg;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_reg <= '0;
      rd_valid_reg <= 1'b0;
      nv_done_reg <= 1'b0;
    end else begin
      if (capture) begin
        rdata_reg <= dq_sync_reg;
      end
      rd_valid_reg <= (state_reg == nvh_pkg::ST_RECOVER) && !in_seq_reg;
      nv_done_reg <= (state_reg == nvh_pkg::ST_NVWAIT) && timer_done;
    end
  end

  // strobe width, busy and power-up waits share one counter
  nvh_timer #(
    .CNT_W(CW),
    .INIT(CW'(POWERUP_CYCLES - 1))
  ) u_timer (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .load_i(timer_load),
    .load_val_i(timer_val),
    .done_o(timer_done)
  );

  // outputs
  assign ready_o = in_idle;
  assign busy_o = !in_idle;
  assign rd_valid_o = rd_valid_reg;
  assign rd_data_o = rdata_reg;
  assign nv_done_o = nv_done_reg;
  assign mem_addr_o = addr_reg;
  assign mem_ce_n_o = ce_n_reg;
  assign mem_we_n_o = we_n_reg;
  assign mem_oe_n_o = oe_n_reg;
  assign mem_dq_o = wdata_reg;
  assign mem_dq_oe_o = dq_oe_reg;

  // expected sequence address for the step on the pins
  wire [nvh_pkg::SEQ_ADDR_W-1:0] seq_expect = seq_last ?
       (kind_reg ? nvh_pkg::SEQ_RESTORE_LAST : nvh_pkg::SEQ_SAVE_LAST) :
       nvh_pkg::SEQ_PREFIX[step_reg];

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  chk_read_we_high: assert property (
    (!mem_ce_n_o && !is_write_reg) |-> mem_we_n_o)
    else $error("write strobe low during a read");
  chk_write_we_low: assert property (
    (!mem_ce_n_o && is_write_reg) |-> (!mem_we_n_o && mem_dq_oe_o))
    else $error("write access without write strobe");
  chk_seq_we_high: assert property (
    in_seq_reg |-> (mem_we_n_o && !mem_dq_oe_o))
    else $error("write strobe low inside sequence");
  chk_seq_addr_order: assert property (
    (in_seq_reg && $fell(mem_ce_n_o)) |->
    (mem_addr_o == {1'b0, seq_expect}))
    else $error("sequence address out of order");
  chk_ce_pulse_end: assert property (
    $fell(mem_ce_n_o) |-> ##[1:20] $rose(mem_ce_n_o))
    else $error("chip select not released after strobe");
  chk_addr_ce_high: assert property (
    $changed(mem_addr_o) |-> (mem_ce_n_o && $past(mem_ce_n_o)))
    else $error("address changed with chip select low");
  chk_nvwait_quiet: assert property (
    (state_reg == nvh_pkg::ST_NVWAIT) |-> (mem_ce_n_o && !ready_o))
    else $error("access during nonvolatile busy time");
  chk_seq_then_wait: assert property (
    (state_reg == nvh_pkg::ST_RECOVER && in_seq_reg && seq_last) |=>
    (state_reg == nvh_pkg::ST_NVWAIT))
    else $error("sixth read did not enter busy wait");

  cov_save_done: cover property (nv_done_o && !kind_reg);
  cov_restore_done: cover property (nv_done_o && kind_reg);
  cov_read: cover property (rd_valid_o && !is_write_reg);
  cov_write: cover property (rd_valid_o && is_write_reg);
endmodule

// [nvh_dev_model.sv]
// behavioural nonvolatile sram: array, shadow, software save and restore
// assumes the host drives the pins and the data wire is resolved outside
`timescale 1ns/1ps
module nvh_dev_model #(
  parameter int SAVE_NS = 150,
  parameter int RESTORE_NS = 100,
  parameter int PWRUP_NS = 150
) (
  input wire logic [14:0] addr_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic dq_oe_o,
  output int save_count_o,
  output int restore_count_o
);
  logic [7:0] sram [0:32767]; // working array
  logic [7:0] shadow [0:32767]; // nonvolatile copy
  logic busy; // whole chip disabled
  logic float_acc; // this access keeps outputs off
  logic dirty; // write since last save or restore
  int step; // matched sequence steps
  wire logic [13:0] low = addr_i[13:0];

  // clear first, then copy; shadow left alone
  task automatic restore_all();
    for (int i = 0; i < 32768; i++) sram[i] = 8'h00;
    for (int i = 0; i < 32768; i++) sram[i] = shadow[i];
    dirty = 1'b0;
  endtask

  // power-up restore holds the chip busy until done
  initial begin
    busy = 1'b1;
    float_acc = 1'b0;
    step = 0;
    save_count_o = 0;
    restore_count_o = 0;
    for (int i = 0; i < 32768; i++) shadow[i] = i[7:0] ^ 8'h5a;
    #PWRUP_NS;
    restore_all();
    busy = 1'b0;
  end

  // sequence steps are counted on chip select falls only
  always @(negedge ce_n_i) begin
    if (!busy) begin
      float_acc = !we_n_i;
      if (!we_n_i) begin
        step = 0;
      end else if (step == 5 && (low == nvh_pkg::SEQ_SAVE_LAST ||
          low == nvh_pkg::SEQ_RESTORE_LAST)) begin
        float_acc = 1'b1;
        busy = 1'b1;
        step = 0;
        if (low == nvh_pkg::SEQ_SAVE_LAST) begin
          for (int i = 0; i < 32768; i++) shadow[i] = sram[i];
          dirty = 1'b0;
          save_count_o++;
          #SAVE_NS;
        end else begin
          restore_all();
          restore_count_o++;
          #RESTORE_NS;
        end
        busy = 1'b0;
      end else if (step < 5 && low == nvh_pkg::SEQ_PREFIX[step]) begin
        step++;
      end else begin
        step = (low == nvh_pkg::SEQ_PREFIX[0]) ? 1 : 0;
      end
    end
  end

  // level write while both strobes low
  always @(ce_n_i, we_n_i, addr_i, dq_i) begin
    if (!ce_n_i && !we_n_i && !busy) begin
      sram[addr_i] = dq_i;
      dirty = 1'b1;
    end
  end

  // read drive; off while busy or for a floated access
  assign dq_oe_o = !ce_n_i && !oe_n_i && we_n_i && !float_acc && !busy;
  assign dq_o = sram[addr_i];
endmodule

// [tb_top.sv]
// self-checking bench for the nonvolatile sram host controller
// assumes the behavioural memory model on the far side of the pins
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  fails++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic clock_i = 0, reset_i = 1, req_valid_i = 0, req_write_i = 0;
  logic save_req_i = 0, restore_req_i = 0;
  logic [14:0] req_addr_i = '0;
  logic [7:0] req_wdata_i = '0;
  wire logic ready_o, rd_valid_o, nv_done_o, busy_o, ce_n, we_n, oe_n;
  wire logic host_oe, dev_oe;
  wire logic [7:0] rd_data_o, host_q, dev_q, dq;
  wire logic [14:0] addr;
  int save_cnt, restore_cnt, fails = 0, compares = 0, cyc = 0, pin_bad = 0;
  logic [7:0] last_dq = 8'h00, q; // inverse shows on a floating wire
  logic [14:0] prev_addr = '0;
  logic prev_sel = 0;
  logic [15:0] seq_q[$]; // {we_n, addr} at each chip select fall
  assign dq = host_oe ? host_q : dev_oe ? dev_q : ~last_dq;

  nvh_host #(.SAVE_CYCLES(20), .RESTORE_CYCLES(20), .POWERUP_CYCLES(20))
    nvh_host_inst (.clock_i(clock_i), .reset_i(reset_i),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .save_req_i(save_req_i), .restore_req_i(restore_req_i),
    .ready_o(ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .nv_done_o(nv_done_o), .busy_o(busy_o), .mem_addr_o(addr),
    .mem_ce_n_o(ce_n), .mem_we_n_o(we_n), .mem_oe_n_o(oe_n),
    .mem_dq_o(host_q), .mem_dq_oe_o(host_oe), .mem_dq_i(dq));
  nvh_dev_model nvh_dev_model_inst (.addr_i(addr), .ce_n_i(ce_n),
    .we_n_i(we_n), .oe_n_i(oe_n), .dq_i(dq), .dq_o(dev_q),
    .dq_oe_o(dev_oe), .save_count_o(save_cnt),
    .restore_count_o(restore_cnt));

  always #5 clock_i = ~clock_i;
  // pin watch: strobe levels and address stability while selected
  always @(negedge clock_i) begin
    if (host_oe || dev_oe) last_dq <= dq;
    if (!ce_n && !oe_n && !we_n) pin_bad++;
    if (!ce_n && prev_sel && addr !== prev_addr) pin_bad++;
    prev_sel <= !ce_n;
    prev_addr <= addr;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  always @(negedge ce_n) seq_q.push_back({we_n, addr});

  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // one user access, held until taken, then wait for completion
  task automatic access(input logic wr, input logic [14:0] a,
      input logic [7:0] d, output logic [7:0] rq);
    int n;
    @(negedge clock_i);
    req_valid_i = 1;
    req_write_i = wr;
    req_addr_i = a;
    req_wdata_i = d;
    for (n = 0; ready_o !== 1'b1 && n < 100; n++) @(negedge clock_i);
    @(negedge clock_i);
    req_valid_i = 0;
    for (n = 0; rd_valid_o !== 1'b1 && n < 20; n++) @(negedge clock_i);
    `CHK("rd_valid_o", 1'b1, rd_valid_o)
    rq = rd_data_o;
  endtask

  // software save or restore with pin sequence check
  task automatic nv_op(input logic sv);
    int n;
    logic [15:0] e;
    seq_q.delete();
    @(negedge clock_i);
    save_req_i = sv;
    restore_req_i = !sv;
    for (n = 0; ready_o !== 1'b1 && n < 100; n++) @(negedge clock_i);
    @(negedge clock_i);
    save_req_i = 0;
    restore_req_i = 0;
    @(negedge clock_i);
    `CHK("ready_o busy", 1'b0, ready_o)
    `CHK("busy_o", 1'b1, busy_o)
    for (n = 0; nv_done_o !== 1'b1 && n < 300; n++) @(negedge clock_i);
    `CHK("nv wait", 1'b1, nv_done_o === 1'b1 && n >= 70)
    `CHK("ce falls", 6, seq_q.size())
    for (int i = 0; i < 6; i++) begin
      e = {2'b10, i < 5 ? nvh_pkg::SEQ_PREFIX[i] : sv ?
        nvh_pkg::SEQ_SAVE_LAST : nvh_pkg::SEQ_RESTORE_LAST};
      `CHK("seq step", e, seq_q[i])
    end
  endtask

  // reset levels, power-up wait and restored contents
  task automatic test_reset();
    int n;
    @(negedge clock_i);
    `CHK("ce_n in reset", 3'b111, {ce_n, we_n, oe_n})
    `CHK("ready in reset", 2'b00, {ready_o, host_oe})
    repeat (7) @(negedge clock_i);
    reset_i = 0;
    for (n = 0; ready_o !== 1'b1 && n < 40; n++) @(negedge clock_i);
    `CHK("powerup wait", 1'b1, n >= 19 && n <= 22)
    access(0, 15'h0101, 8'h00, q);
    `CHK("powerup data", 8'h5b, q)
  endtask

  // plain write and read back, then save and restore round trip
  task automatic test_save_restore();
    access(1, 15'h4100, 8'h3c, q);
    access(0, 15'h4100, 8'h00, q);
    `CHK("read back", 8'h3c, q)
    nv_op(1);
    `CHK("save count", 1, save_cnt)
    access(1, 15'h4100, 8'hc3, q);
    nv_op(0);
    `CHK("restore count", 1, restore_cnt)
    access(0, 15'h4100, 8'h00, q);
    `CHK("restored", 8'h3c, q)
  endtask

  // user reads of the sequence: broken by a write, then high bit set
  task automatic test_abort();
    for (int i = 0; i < 5; i++)
      access(0, {1'b0, nvh_pkg::SEQ_PREFIX[i]}, 8'h00, q);
    access(1, 15'h0200, 8'h11, q);
    access(0, {1'b0, nvh_pkg::SEQ_SAVE_LAST}, 8'h00, q);
    `CHK("aborted save", 1, save_cnt)
    for (int i = 0; i < 5; i++)
      access(0, {1'b1, nvh_pkg::SEQ_PREFIX[i]}, 8'h00, q);
    access(0, {1'b1, nvh_pkg::SEQ_SAVE_LAST}, 8'h00, q);
    `CHK("high bit save", 2, save_cnt)
    repeat (20) @(negedge clock_i);
    access(0, 15'h0200, 8'h00, q);
    `CHK("after save", 8'h11, q)
  endtask

  initial begin
    test_reset();
    test_save_restore();
    test_abort();
    `CHK("pin faults", 0, pin_bad)
    complete_run();
  end
endmodule
